// ===== rtl/fct_pkg.sv
// Constants, types and register map of the flow conditioning totalizer.
package fct_pkg;
  // ---------------------------------------------------------------
  // Timing.
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
  localparam real FAULT_DELAY_S = 2.7000;
  localparam logic [31:0] DELAY_RST = 32'($rtoi(FAULT_DELAY_S * 1000.0 + 0.5));
  // ---------------------------------------------------------------
  // Register byte offsets.
  // ---------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_THRESH = 8'h04;
  localparam logic [7:0] A_FSCALE = 8'h08;
  localparam logic [7:0] A_KFACT = 8'h0c;
  localparam logic [7:0] A_MPRESS = 8'h10;
  localparam logic [7:0] A_ONDLY = 8'h14;
  localparam logic [7:0] A_OFFDLY = 8'h18;
  localparam logic [7:0] A_CMD = 8'h1c;
  localparam logic [7:0] A_FLOW = 8'h20;
  localparam logic [7:0] A_TOTAL = 8'h24;
  localparam logic [7:0] A_FAILTOT = 8'h28;
  localparam logic [7:0] A_BATCH = 8'h2c;
  localparam logic [7:0] A_CPRESS = 8'h30;
  localparam logic [7:0] A_STATUS = 8'h34;
  localparam logic [7:0] A_IRQSTAT = 8'h38;
  localparam logic [7:0] A_IRQMASK = 8'h3c;
  localparam logic [7:0] A_DTHRESH = 8'h40;
  // ---------------------------------------------------------------
  // Fields, masks and reset values.
  // ---------------------------------------------------------------
  localparam int unsigned C_REV = 0;
  localparam int unsigned C_KEY = 1;
  localparam int unsigned C_TM = 2;
  localparam int unsigned C_PM = 4;
  localparam int unsigned C_AIN = 6;
  localparam int unsigned CMD_RST_TOTAL = 0;
  localparam int unsigned FRAC_SHIFT = 16;
  localparam logic [31:0] M_THRESH = 32'h0000_ffff;
  localparam logic [31:0] M_FSCALE = 32'h00ff_ffff;
  localparam logic [31:0] M_16 = 32'h0000_ffff;
  localparam logic [31:0] KFACT_RST = 32'h0001_0000;
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned I_FON = 0;
  localparam int unsigned I_FOFF = 1;
  localparam int unsigned I_BCLR = 2;
  localparam int unsigned I_PREF = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {TM_DEFAULT = 2'h0, TM_FORWARD = 2'h1, TM_BACKWARD = 2'h2} fct_tmode_type;
  typedef enum logic [1:0] {PM_OFF = 2'h0, PM_ANALOG = 2'h1, PM_MANUAL = 2'h2} fct_pmode_type;
  typedef enum logic [1:0] {FS_IDLE = 2'b00, FS_ARM = 2'b01, FS_ACTIVE = 2'b11,
                            FS_RELEASE = 2'b10} fct_fstate_type;
endpackage

// ===== rtl/fct_top.sv
// Flow conditioning, totalizer and fault delay block with AXI4-Lite registers.
`timescale 1ns/1ps
`default_nettype none
module fct_top #(
  parameter int unsigned TICK_CYCLES = fct_pkg::TICK_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [23:0] flow_in,
  input wire logic flow_in_valid,
  input wire logic error_in,
  input wire logic batch_clear_button,
  input wire logic [15:0] analog_pressure_input,
  output logic [31:0] flow_out,
  output logic flow_out_valid,
  output logic flow_suppressed,
  output logic [31:0] total_out,
  output logic [31:0] batch_out,
  output logic [15:0] comp_pressure,
  output logic fault_lamp,
  output logic fault_output,
  output logic irq
);
  // ---------------------------------------------------------------
  // Declarations.
  // ---------------------------------------------------------------
  logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic wr_fire, rd_fire, wr_hit, rd_hit;
  logic [31:0] rd_val;
  logic rev_q, key_q, ain_q;
  fct_pkg::fct_tmode_type tmode_q;
  fct_pkg::fct_pmode_type pmode_q, pmode_new;
  logic [31:0] thresh_q, fscale_q, kfact_q, mpress_q, ondly_q, offdly_q, dthresh_q;
  logic [31:0] ctrl_word, ctrl_new;
  logic pref_ev, rst_tot_q;
  logic signed [24:0] flow_ext, signed_flow, abs_flow;
  logic [39:0] thr_prod;
  logic suppress_c;
  logic signed [56:0] scaled_c;
  logic signed [31:0] flow_q;
  logic valid_q, supp_q;
  logic [31:0] total_q, fail_q, batch_q;
  logic batch_clr;
  logic [15:0] cpress_q;
  fct_pkg::fct_fstate_type fstate_q;
  logic [31:0] tick_cnt_q, dly_q;
  logic tick;
  logic fault_on;
  logic [fct_pkg::IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_set;
  logic [31:0] mask_new;

  // Merge a write word into an old value under the byte strobes.
  function automatic logic [31:0] fct_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // AXI4-Lite write channels.
  // ---------------------------------------------------------------
  // Address and data are latched separately, so they may come in any order.
  assign awready = !aw_have_q;
  assign wready = !w_have_q;
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= awaddr;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      if (wvalid && wready) begin
        w_have_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // Write response; unmapped or read-only offsets answer with SLVERR.
  always_comb begin
    case (aw_addr_q)
      fct_pkg::A_CTRL, fct_pkg::A_THRESH, fct_pkg::A_FSCALE, fct_pkg::A_KFACT,
      fct_pkg::A_MPRESS, fct_pkg::A_ONDLY, fct_pkg::A_OFFDLY, fct_pkg::A_CMD,
      fct_pkg::A_IRQMASK, fct_pkg::A_DTHRESH: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= fct_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? fct_pkg::RESP_OKAY : fct_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers.
  // ---------------------------------------------------------------
  assign ctrl_word = {25'h0, ain_q, pmode_q, tmode_q, key_q, rev_q};
  assign ctrl_new = fct_merge(ctrl_word, w_data_q, w_strb_q);
  // The mask is merged as a full word first, since a function result cannot be sliced.
  assign mask_new = fct_merge({28'h0, irq_mask_q}, w_data_q, w_strb_q);

  // An analog source picked while the analog input is off keeps the old mode.
  always_comb begin
    pmode_new = fct_pkg::fct_pmode_type'(ctrl_new[fct_pkg::C_PM +: 2]);
    pref_ev = 1'b0;
    if (pmode_new == fct_pkg::PM_ANALOG && !ctrl_new[fct_pkg::C_AIN]) begin
      pmode_new = pmode_q;
      pref_ev = wr_fire && aw_addr_q == fct_pkg::A_CTRL;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rev_q <= 1'b0;
      key_q <= 1'b0;
      ain_q <= 1'b0;
      tmode_q <= fct_pkg::TM_DEFAULT;
      pmode_q <= fct_pkg::PM_OFF;
      thresh_q <= 32'h0000_0000;
      fscale_q <= 32'h0000_0000;
      kfact_q <= fct_pkg::KFACT_RST;
      mpress_q <= 32'h0000_0000;
      ondly_q <= fct_pkg::DELAY_RST;
      offdly_q <= fct_pkg::DELAY_RST;
      dthresh_q <= 32'h0000_0000;
      irq_mask_q <= '0;
    end else if (wr_fire) begin
      case (aw_addr_q)
        fct_pkg::A_CTRL: begin
          rev_q <= ctrl_new[fct_pkg::C_REV];
          key_q <= ctrl_new[fct_pkg::C_KEY];
          ain_q <= ctrl_new[fct_pkg::C_AIN];
          tmode_q <= fct_pkg::fct_tmode_type'(ctrl_new[fct_pkg::C_TM +: 2]);
          pmode_q <= pmode_new;
        end
        fct_pkg::A_THRESH: thresh_q <= fct_merge(thresh_q, w_data_q, w_strb_q) & fct_pkg::M_THRESH;
        fct_pkg::A_FSCALE: fscale_q <= fct_merge(fscale_q, w_data_q, w_strb_q) & fct_pkg::M_FSCALE;
        fct_pkg::A_KFACT: kfact_q <= fct_merge(kfact_q, w_data_q, w_strb_q);
        fct_pkg::A_MPRESS: mpress_q <= fct_merge(mpress_q, w_data_q, w_strb_q) & fct_pkg::M_16;
        fct_pkg::A_ONDLY: ondly_q <= fct_merge(ondly_q, w_data_q, w_strb_q);
        fct_pkg::A_OFFDLY: offdly_q <= fct_merge(offdly_q, w_data_q, w_strb_q);
        fct_pkg::A_DTHRESH: dthresh_q <= fct_merge(dthresh_q, w_data_q, w_strb_q);
        fct_pkg::A_IRQMASK: begin
          irq_mask_q <= mask_new[fct_pkg::IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // The command register is write-only and yields a one-cycle pulse.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_tot_q <= 1'b0;
    end else begin
      rst_tot_q <= wr_fire && aw_addr_q == fct_pkg::A_CMD && w_strb_q[0] &&
                   w_data_q[fct_pkg::CMD_RST_TOTAL];
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channel.
  // ---------------------------------------------------------------
  assign arready = !rvalid_q;
  assign rd_fire = arvalid && arready;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  always_comb begin
    rd_hit = 1'b1;
    case (araddr)
      fct_pkg::A_CTRL: rd_val = ctrl_word;
      fct_pkg::A_THRESH: rd_val = thresh_q;
      fct_pkg::A_FSCALE: rd_val = fscale_q;
      fct_pkg::A_KFACT: rd_val = kfact_q;
      fct_pkg::A_MPRESS: rd_val = mpress_q;
      fct_pkg::A_ONDLY: rd_val = ondly_q;
      fct_pkg::A_OFFDLY: rd_val = offdly_q;
      fct_pkg::A_CMD: rd_val = 32'h0000_0000;
      fct_pkg::A_FLOW: rd_val = flow_q;
      fct_pkg::A_TOTAL: rd_val = total_q;
      fct_pkg::A_FAILTOT: rd_val = fail_q;
      fct_pkg::A_BATCH: rd_val = batch_q;
      fct_pkg::A_CPRESS: rd_val = {16'h0000, cpress_q};
      fct_pkg::A_STATUS: rd_val = {30'h0, supp_q, fault_on};
      fct_pkg::A_IRQSTAT: rd_val = {28'h0, irq_stat_q};
      fct_pkg::A_IRQMASK: rd_val = {28'h0, irq_mask_q};
      fct_pkg::A_DTHRESH: rd_val = dthresh_q;
      default: begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= fct_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= rd_hit ? fct_pkg::RESP_OKAY : fct_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Flow conditioning.
  // ---------------------------------------------------------------
  // Widened by one bit first so that negating the most negative sample cannot wrap.
  assign flow_ext = {flow_in[23], flow_in};
  assign signed_flow = rev_q ? -flow_ext : flow_ext;
  assign abs_flow = signed_flow[24] ? -signed_flow : signed_flow;
  assign thr_prod = fscale_q[23:0] * thresh_q[15:0];
  assign suppress_c = abs_flow < $signed({1'b0, thr_prod[39:fct_pkg::FRAC_SHIFT]});
  assign scaled_c = signed_flow * $signed(kfact_q);

  // One register stage; the product is cut to a 32-bit result on purpose.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flow_q <= 32'sh0000_0000;
      valid_q <= 1'b0;
      supp_q <= 1'b0;
    end else begin
      valid_q <= flow_in_valid;
      if (flow_in_valid) begin
        supp_q <= suppress_c;
        flow_q <= suppress_c ? 32'sh0000_0000 : scaled_c[fct_pkg::FRAC_SHIFT +: 32];
      end
    end
  end

  assign flow_out = flow_q;
  assign flow_out_valid = valid_q;
  assign flow_suppressed = supp_q;

  // ---------------------------------------------------------------
  // Totalizer, failure total and batch.
  // ---------------------------------------------------------------
  // Clearing takes priority over a sample landing in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      total_q <= 32'h0000_0000;
      fail_q <= 32'h0000_0000;
    end else if (rst_tot_q) begin
      total_q <= 32'h0000_0000;
      fail_q <= 32'h0000_0000;
    end else if (valid_q && !supp_q) begin
      case (tmode_q)
        fct_pkg::TM_DEFAULT: total_q <= total_q + flow_q;
        fct_pkg::TM_FORWARD: if (!flow_q[31]) total_q <= total_q + flow_q;
        fct_pkg::TM_BACKWARD: if (flow_q[31]) total_q <= total_q + flow_q;
        default: begin
        end
      endcase
      if (fault_on) begin
        fail_q <= fail_q + flow_q;
      end
    end
  end

  assign batch_clr = batch_clear_button && key_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      batch_q <= 32'h0000_0000;
    end else if (batch_clr) begin
      batch_q <= 32'h0000_0000;
    end else if (valid_q && !supp_q) begin
      batch_q <= batch_q + flow_q;
    end
  end

  assign total_out = total_q;
  assign batch_out = batch_q;

  // ---------------------------------------------------------------
  // Pressure compensation source.
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpress_q <= 16'h0000;
    end else begin
      case (pmode_q)
        fct_pkg::PM_ANALOG: cpress_q <= analog_pressure_input;
        fct_pkg::PM_MANUAL: cpress_q <= mpress_q[15:0];
        default: cpress_q <= 16'h0000;
      endcase
    end
  end

  assign comp_pressure = cpress_q;

  // ---------------------------------------------------------------
  // Fault delay.
  // ---------------------------------------------------------------
  // A fixed millisecond tick keeps the delay registers small.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_q <= 32'h0000_0000;
    end else if (tick) begin
      tick_cnt_q <= 32'h0000_0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end

  assign tick = tick_cnt_q == 32'(TICK_CYCLES - 1);

  // The delay count restarts on every change of the error state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fstate_q <= fct_pkg::FS_IDLE;
      dly_q <= 32'h0000_0000;
    end else begin
      case (fstate_q)
        fct_pkg::FS_IDLE: begin
          dly_q <= 32'h0000_0000;
          if (error_in) fstate_q <= fct_pkg::FS_ARM;
        end
        fct_pkg::FS_ARM: begin
          if (!error_in) begin
            fstate_q <= fct_pkg::FS_IDLE;
          end else if (dly_q >= ondly_q) begin
            fstate_q <= fct_pkg::FS_ACTIVE;
            dly_q <= 32'h0000_0000;
          end else if (tick) begin
            dly_q <= dly_q + 32'h0000_0001;
          end
        end
        fct_pkg::FS_ACTIVE: begin
          dly_q <= 32'h0000_0000;
          if (!error_in) fstate_q <= fct_pkg::FS_RELEASE;
        end
        fct_pkg::FS_RELEASE: begin
          if (error_in) begin
            fstate_q <= fct_pkg::FS_ACTIVE;
            dly_q <= 32'h0000_0000;
          end else if (dly_q >= offdly_q) begin
            fstate_q <= fct_pkg::FS_IDLE;
          end else if (tick) begin
            dly_q <= dly_q + 32'h0000_0001;
          end
        end
        default: fstate_q <= fct_pkg::FS_IDLE;
      endcase
    end
  end

  assign fault_on = fstate_q == fct_pkg::FS_ACTIVE || fstate_q == fct_pkg::FS_RELEASE;
  assign fault_lamp = fault_on;
  assign fault_output = fault_on;

  // ---------------------------------------------------------------
  // Interrupts.
  // ---------------------------------------------------------------
  assign irq_set[fct_pkg::I_FON] = fstate_q == fct_pkg::FS_ARM && error_in && dly_q >= ondly_q;
  assign irq_set[fct_pkg::I_FOFF] = fstate_q == fct_pkg::FS_RELEASE && !error_in &&
                                    dly_q >= offdly_q;
  assign irq_set[fct_pkg::I_BCLR] = batch_clr;
  assign irq_set[fct_pkg::I_PREF] = pref_ev;

  // A read clears the status, but an event in the same cycle survives it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= '0;
    end else if (rd_fire && araddr == fct_pkg::A_IRQSTAT) begin
      irq_stat_q <= irq_set;
    end else begin
      irq_stat_q <= irq_stat_q | irq_set;
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // ---------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_suppress;
    flow_in_valid && suppress_c |=> flow_q == 0 && flow_out_valid && flow_suppressed;
  endproperty
  a_suppress: assert property (p_suppress) else $error("Suppressed flow not zero.");

  property p_hold;
    valid_q && supp_q && !rst_tot_q && !batch_clr |=> $stable(total_q) && $stable(batch_q);
  endproperty
  a_hold: assert property (p_hold) else $error("Total moved while suppressed.");

  property p_bclr;
    batch_clear_button && key_q |=> batch_q == 0 ##0 irq_stat_q[fct_pkg::I_BCLR];
  endproperty
  a_bclr: assert property (p_bclr) else $error("Batch not cleared.");

  property p_bign;
    batch_clear_button && !key_q && !valid_q |=> $stable(batch_q);
  endproperty
  a_bign: assert property (p_bign) else $error("Disabled button cleared batch.");

  property p_fwd;
    valid_q && tmode_q == fct_pkg::TM_FORWARD && flow_q[31] && !rst_tot_q |=> $stable(total_q);
  endproperty
  a_fwd: assert property (p_fwd) else $error("Forward mode counted negative flow.");

  property p_bwd;
    valid_q && tmode_q == fct_pkg::TM_BACKWARD && !flow_q[31] && !rst_tot_q |=> $stable(total_q);
  endproperty
  a_bwd: assert property (p_bwd) else $error("Backward mode counted positive flow.");

  property p_rst_tot;
    rst_tot_q |=> total_q == 0 && fail_q == 0;
  endproperty
  a_rst_tot: assert property (p_rst_tot) else $error("Totals not cleared.");

  property p_fon;
    $rose(fault_on) |-> $past(error_in) && $past(dly_q) >= $past(ondly_q);
  endproperty
  a_fon: assert property (p_fon) else $error("Fault asserted early.");

  property p_foff;
    $fell(fault_on) |-> !$past(error_in) && $past(dly_q) >= $past(offdly_q);
  endproperty
  a_foff: assert property (p_foff) else $error("Fault released early.");

  property p_refuse;
    wr_fire && aw_addr_q == fct_pkg::A_CTRL && !ctrl_new[fct_pkg::C_AIN] &&
      ctrl_new[fct_pkg::C_PM +: 2] == fct_pkg::PM_ANALOG |=> $stable(pmode_q);
  endproperty
  a_refuse: assert property (p_refuse) else $error("Analog source accepted.");

  property p_manual;
    pmode_q == fct_pkg::PM_MANUAL && $stable(pmode_q) |=> cpress_q == $past(mpress_q[15:0]);
  endproperty
  a_manual: assert property (p_manual) else $error("Manual pressure not used.");

  property p_c_fault;
    $rose(fault_on) ##[1:1000] $fell(fault_on);
  endproperty
  c_fault: cover property (p_c_fault);

  property p_c_supp;
    flow_in_valid && suppress_c ##1 flow_in_valid && !suppress_c;
  endproperty
  c_supp: cover property (p_c_supp);

  property p_c_refuse;
    pref_ev ##[1:20] irq;
  endproperty
  c_refuse: cover property (p_c_refuse);
endmodule
`default_nettype wire

// ===== dv/fct_front.sv
// Behavioural model of the flow sensor front end.
`timescale 1ns/1ps
`default_nettype none
module fct_front (
  input wire logic aclk,
  input wire logic req,
  input wire logic [23:0] val,
  input wire logic err,
  output logic [23:0] flow_in = 24'h5a5a5a,
  output logic flow_in_valid = 1'b0,
  output logic error_in = 1'b0
);
  // Between samples the data lines toggle, so a stale value is never mistaken for a sample.
  always @(posedge aclk) begin
    flow_in_valid <= req;
    flow_in <= req ? val : ~flow_in;
    error_in <= err;
  end
endmodule
`default_nettype wire

// ===== dv/flow_conditioning_totalizer_test.sv
// Self-checking bench of the flow conditioning totalizer.
`timescale 1ns/1ps
`default_nettype none
module flow_conditioning_totalizer_test;
  logic aclk = 1'b0, aresetn = 1'b0, req = 1'b0, err = 1'b0, btn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rval, rdata, flow_out, total_out, batch_out;
  logic [23:0] val = 24'h0, flow_in;
  logic [15:0] apin = 16'h0abc, comp_pressure;
  logic awready, wready, bvalid, arready, rvalid, flow_in_valid, error_in, x, y;
  logic flow_out_valid, flow_suppressed, fault_lamp, fault_output, irq;
  logic [1:0] bresp, rresp;
  int err_total = 0, checked = 0;
  fct_front u_front (.aclk, .req, .val, .err, .flow_in, .flow_in_valid, .error_in);
  fct_top #(.TICK_CYCLES(4)) u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .flow_in, .flow_in_valid, .error_in,
    .batch_clear_button(btn), .analog_pressure_input(apin), .flow_out, .flow_out_valid,
    .flow_suppressed, .total_out, .batch_out, .comp_pressure, .fault_lamp, .fault_output, .irq);
  // Free-running 25 MHz clock.
  initial begin
    forever #20 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Ready is sampled mid-cycle, where it is settled, and acted on at the next edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      x = awready;
      y = wready;
      @(posedge aclk);
      if (x) awvalid <= 1'b0;
      if (y) wvalid <= 1'b0;
      if (bvalid) bready <= 1'b0;
    end while (awvalid || wvalid || bready);
    @(negedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      x = arready;
      y = rvalid;
      if (y) rval = rdata;
      @(posedge aclk);
      if (x) arvalid <= 1'b0;
      if (y) rready <= 1'b0;
    end while (arvalid || rready);
    @(negedge aclk);
  endtask
  task automatic snd(input logic [23:0] v);
    @(posedge aclk);
    req <= 1'b1;
    val <= v;
    @(posedge aclk);
    req <= 1'b0;
    @(posedge aclk);
    @(negedge aclk);
    chk({31'h0, flow_out_valid}, 32'h1);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic hold(input logic e, input int n, input logic b);
    @(posedge aclk);
    err <= e;
    btn <= b;
    repeat (n) @(posedge aclk);
    btn <= 1'b0;
    @(negedge aclk);
  endtask
  task automatic s_flow;
    rd(fct_pkg::A_KFACT);
    chk(rval, 32'h0001_0000);
    rd(8'hfc);
    chk({30'h0, rresp}, 32'h2);
    wr(fct_pkg::A_FLOW, 32'h1);
    chk({30'h0, bresp}, 32'h2);
    wr(fct_pkg::A_DTHRESH, 32'h0);
    wr(fct_pkg::A_FSCALE, 32'h0001_0000);
    wr(fct_pkg::A_THRESH, 32'h0000_0100);
    snd(24'd100);
    chk({31'h0, flow_suppressed}, 32'h1);
    chk(flow_out, 32'h0);
    chk(total_out, 32'h0);
    snd(24'd300);
    chk(flow_out, 32'd300);
    wr(fct_pkg::A_CTRL, 32'h1);
    snd(24'd300);
    chk(flow_out, 32'hffff_fed4);
    chk(total_out, 32'h0);
    wr(fct_pkg::A_KFACT, 32'h0002_0000);
    wr(fct_pkg::A_CTRL, 32'h5);
    snd(24'd300);
    chk(flow_out, 32'hffff_fda8);
    chk(total_out, 32'h0);
    wr(fct_pkg::A_CTRL, 32'h8);
    snd(24'd300);
    chk(total_out, 32'h0);
    snd(24'hfffed4);
    chk(total_out, 32'hffff_fda8);
    wr(fct_pkg::A_CMD, 32'h1);
    chk(total_out, 32'h0);
  endtask
  task automatic s_batch;
    wr(fct_pkg::A_CTRL, 32'h2);
    hold(1'b0, 1, 1'b1);
    chk(batch_out, 32'h0);
    wr(fct_pkg::A_CTRL, 32'h0);
    snd(24'd300);
    hold(1'b0, 1, 1'b1);
    chk(batch_out, 32'd600);
  endtask
  task automatic s_press;
    wr(fct_pkg::A_MPRESS, 32'h1234);
    wr(fct_pkg::A_CTRL, 32'h20);
    chk({16'h0, comp_pressure}, 32'h1234);
    wr(fct_pkg::A_CTRL, 32'h10);
    chk({16'h0, comp_pressure}, 32'h1234);
    chk({31'h0, irq}, 32'h0);
    wr(fct_pkg::A_IRQMASK, 32'h8);
    chk({31'h0, irq}, 32'h1);
    rd(fct_pkg::A_IRQSTAT);
    chk(rval & 32'h8, 32'h8);
    chk({31'h0, irq}, 32'h0);
    wr(fct_pkg::A_CTRL, 32'h50);
    chk({16'h0, comp_pressure}, 32'h0abc);
    wr(fct_pkg::A_CTRL, 32'h40);
    chk({16'h0, comp_pressure}, 32'h0);
  endtask
  // Delays of 5 ticks of 4 clocks; a tick may be partial, so margins cover one tick.
  task automatic s_fault;
    wr(fct_pkg::A_ONDLY, 32'd5);
    wr(fct_pkg::A_OFFDLY, 32'd5);
    hold(1'b1, 10, 1'b0);
    hold(1'b0, 4, 1'b0);
    hold(1'b1, 12, 1'b0);
    chk({31'h0, fault_lamp}, 32'h0);
    hold(1'b1, 21, 1'b0);
    chk({30'h0, fault_lamp, fault_output}, 32'h3);
    // While the fault stands, a sample lands in the failure total.
    snd(24'h00012c);
    rd(fct_pkg::A_FAILTOT);
    chk(rval, 32'h0000_0258);
    wr(fct_pkg::A_CMD, 32'h1);
    rd(fct_pkg::A_FAILTOT);
    chk(rval, 32'h0);
    hold(1'b0, 10, 1'b0);
    chk({30'h0, fault_lamp, fault_output}, 32'h3);
    hold(1'b0, 24, 1'b0);
    chk({30'h0, fault_lamp, fault_output}, 32'h0);
  endtask
  task automatic summarize;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Reset for two cycles, then the scenarios in turn.
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    s_flow;
    s_batch;
    s_press;
    s_fault;
    summarize;
  end
  // The run needs a few hundred cycles; a hang is cut short well beyond that.
  initial begin
    #400000;
    err_total++;
    summarize;
  end
endmodule
`default_nettype wire
